/* dma_pkg.sv */
// Constants, types and decode helpers for the converter-to-XRAM transfer engine.
// Assumes an APB master on pclk and converters and XRAM arbitration on the same clock.
// What this block does
// - Instruction buffer holds 64 entries of 8 bits, loaded by software.
// - Data port write stores at write pointer entry; read returns that entry.
// - Every data port read or write advances the write pointer by one.
// - Instructions only select results to collect; engine never starts conversions.
// - Data instructions write 2 or 4 bytes; end-of-operation writes none.
// - Word 00h is end-of-operation; 80h is end-of-operation with continuous run.
// - Single-ended codes collect first, second, or first then second result.
// - Differential codes write first converter result, optionally then second result.
// - On-chip XRAM writes happen only when the core is not using it.
// - Halt bit 0 gives off-chip XRAM to engine; 1 gives it to core.
// - With halt 0, core off-chip accesses complete but move no data.
// - Pending off-chip writes wait until the halt bit is 0.
// - A new result arriving before the previous is written flags overflow.
// - 16-bit XRAM pointer loads from the start address when enabled.
// - XRAM pointer grows by 2 or 4 after each data instruction.
// - Operation start loads index from boundary, fetches, then waits for results.
// - Mode 0 runs each instruction once, then advances the index.
// - End-of-operation resets the index to the start boundary.
// - Continuous bit set on end-of-operation ignores the repeat counter.
// - Repeat counter loads from limit; plain end-of-operation decrements until zero.
// - Enable write 1 starts, 0 stops; reads 1 while running.
// - Mode select bit is stored and read back; the engine runs mode 0 for both 0 and 1.
// - Off-chip busy reads 1 while the engine accesses off-chip XRAM.
package dma_pkg;
  localparam int IDX_W = 6;
  localparam int BUF_DEPTH = 64;
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IPTR = 8'h04;
  localparam logic [7:0] OFS_IDATA = 8'h08;
  localparam logic [7:0] OFS_XSTART = 8'h0C;
  localparam logic [7:0] OFS_XPTR = 8'h10;
  localparam logic [7:0] OFS_BOUND = 8'h14;
  localparam logic [7:0] OFS_CIDX = 8'h18;
  localparam logic [7:0] OFS_RLIMIT = 8'h1C;
  localparam logic [7:0] OFS_RCOUNT = 8'h20;
  // Control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_HALT = 2;
  localparam int CTL_BUSY = 3;
  localparam int CTL_OVF0 = 4;
  localparam int CTL_OVF1 = 5;
  // Instruction fields
  localparam int INS_CONTINUOUS_CONVERSION_FLAG = 7;
  localparam int INS_DIFF = 6;
  localparam int INS_SEC = 5;
  localparam int INS_FIRST = 4;
  // Reset values and limits
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [IDX_W-1:0] RST_IDX = 6'h00;
  localparam logic [15:0] ONCHIP_LIMIT = 16'h1000;
  localparam logic [2:0] BYTES_WORD = 3'h2;

  typedef enum {S_IDLE, S_FETCH, S_WAIT, S_WRITE} eng_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] data;
  } xram_acc_t;

  function automatic logic is_eop(input logic [7:0] ins);
    return ins[6:0] == 7'h00;
  endfunction : is_eop

  function automatic logic need_first(input logic [7:0] ins);
    return ins[INS_FIRST] | ins[INS_DIFF];
  endfunction : need_first

  function automatic logic [2:0] ins_bytes(input logic [7:0] ins);
    return (need_first(ins) && ins[INS_SEC]) ? 3'h4 : BYTES_WORD;
  endfunction : ins_bytes
endpackage : dma_pkg

/* conv_xram_dma.sv */
// Converter-to-XRAM transfer engine: APB registers, instruction buffer, sequencer, XRAM arbitration.
// Assumes converters, core and XRAM logic all run on pclk; no synchronisers are needed.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module conv_xram_dma (
  input wire logic pclk,
  input wire logic presetn,
  input wire dma_pkg::apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_conv_done,
  input wire logic [15:0] first_conv_result,
  input wire logic second_conv_done,
  input wire logic [15:0] second_conv_result,
  input wire logic core_onchip_busy,
  output logic onchip_we,
  output logic [15:0] xram_addr,
  output logic [7:0] xram_wdata,
  input wire dma_pkg::xram_acc_t core_offchip,
  output logic [7:0] core_offchip_rdata,
  output dma_pkg::xram_acc_t ext_xram,
  input wire logic [7:0] ext_rdata
);
  import dma_pkg::*;

  eng_state_t state;
  logic [7:0] ibuf [BUF_DEPTH];
  logic [IDX_W-1:0] instr_write_pointer;
  logic [IDX_W-1:0] current_instr_index;
  logic [IDX_W-1:0] instr_start_boundary;
  logic [15:0] xram_start;
  logic [15:0] xram_ptr;
  logic [15:0] repeat_limit;
  logic [15:0] repeat_count;
  logic engine_mode_select;
  logic offchip_halt;
  logic ovf0;
  logic ovf1;
  logic [7:0] cur_ins;
  logic buf0_valid;
  logic buf1_valid;
  logic [15:0] buf0;
  logic [15:0] buf1;
  logic [31:0] wr_shift;
  logic [15:0] wr_addr;
  logic [2:0] wr_left;
  logic [2:0] wr_total;

  // APB decode; the slave never stalls
  wire setup = apb.psel & ~apb.penable;
  wire access = apb.psel & apb.penable;
  wire wr_acc = access & apb.pwrite;
  wire hit_ctrl = apb.paddr == OFS_CTRL;
  wire hit_iptr = apb.paddr == OFS_IPTR;
  wire hit_idata = apb.paddr == OFS_IDATA;
  wire hit_xstart = apb.paddr == OFS_XSTART;
  wire hit_xptr = apb.paddr == OFS_XPTR;
  wire hit_bound = apb.paddr == OFS_BOUND;
  wire hit_cidx = apb.paddr == OFS_CIDX;
  wire hit_rlimit = apb.paddr == OFS_RLIMIT;
  wire hit_rcount = apb.paddr == OFS_RCOUNT;
  wire mapped = hit_ctrl | hit_iptr | hit_idata | hit_xstart | hit_xptr | hit_bound | hit_cidx | hit_rlimit | hit_rcount;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Engine control decode
  wire active = state != S_IDLE;
  wire ctrl_wr = wr_acc & hit_ctrl;
  wire start_req = ctrl_wr & apb.pwdata[CTL_EN] & ~active;
  wire stop_req = ctrl_wr & ~apb.pwdata[CTL_EN];
  wire idata_acc = access & hit_idata;
  wire fetched_eop = is_eop(cur_ins);
  wire [15:0] count_dec = repeat_count - 16'h0001;
  wire run_out = ~cur_ins[INS_CONTINUOUS_CONVERSION_FLAG] & (count_dec == RST_16 || repeat_count == RST_16);
  wire want0 = need_first(cur_ins);
  wire want1 = cur_ins[INS_SEC];
  wire data_ready = (~want0 | buf0_valid) & (~want1 | buf1_valid);
  wire to_offchip = wr_addr >= ONCHIP_LIMIT;
  wire offchip_busy = (state == S_WRITE) & to_offchip;
  wire grant = (state == S_WRITE) & (to_offchip ? ~offchip_halt : ~core_onchip_busy);
  wire last_byte = grant & (wr_left == 3'h1);
  wire eng_off_we = grant & to_offchip;
  // Buffers are freed only once their bytes are all in XRAM
  wire consume0 = last_byte & want0;
  wire consume1 = last_byte & want1;
  // Results are taken while the current instruction wants that converter, in the wait or write state
  wire cap_ok0 = active & want0 & (state != S_FETCH);
  wire cap_ok1 = active & want1 & (state != S_FETCH);
  wire lost0 = first_conv_done & buf0_valid & ~consume0;
  wire lost1 = second_conv_done & buf1_valid & ~consume1;

  // XRAM write port; data comes from the shift register flops
  assign onchip_we = grant & ~to_offchip;
  assign xram_addr = wr_addr;
  assign xram_wdata = wr_shift[31:24];

  // Off-chip mux: engine owns the pins while halt is 0
  // Core accesses with halt 0 are swallowed and read back zero
  assign ext_xram.we = offchip_halt ? (core_offchip.we) : eng_off_we;
  assign ext_xram.re = offchip_halt & core_offchip.re;
  assign ext_xram.addr = offchip_halt ? core_offchip.addr : wr_addr;
  assign ext_xram.data = offchip_halt ? core_offchip.data : wr_shift[31:24];
  assign core_offchip_rdata = offchip_halt ? ext_rdata : 8'h00;

  // Read mux, captured in the setup cycle so prdata comes from a flop
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[CTL_EN] = active;
      rd_mux[CTL_MODE] = engine_mode_select;
      rd_mux[CTL_HALT] = offchip_halt;
      rd_mux[CTL_BUSY] = offchip_busy;
      rd_mux[CTL_OVF0] = ovf0;
      rd_mux[CTL_OVF1] = ovf1;
    end
    if (hit_iptr) rd_mux[IDX_W-1:0] = instr_write_pointer;
    if (hit_idata) rd_mux[7:0] = ibuf[instr_write_pointer];
    if (hit_xstart) rd_mux[15:0] = xram_start;
    if (hit_xptr) rd_mux[15:0] = xram_ptr;
    if (hit_bound) rd_mux[IDX_W-1:0] = instr_start_boundary;
    if (hit_cidx) rd_mux[IDX_W-1:0] = current_instr_index;
    if (hit_rlimit) rd_mux[15:0] = repeat_limit;
    if (hit_rcount) rd_mux[15:0] = repeat_count;
  end

  // Instruction buffer has no reset; software loads it before starting
  always_ff @(posedge pclk) begin
    if (idata_acc && apb.pwrite) ibuf[instr_write_pointer] <= apb.pwdata[7:0];
  end

  // Software registers and sticky overflow flags (set wins over clear)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      instr_write_pointer <= RST_IDX;
      instr_start_boundary <= RST_IDX;
      xram_start <= RST_16;
      repeat_limit <= RST_16;
      engine_mode_select <= 1'b0;
      offchip_halt <= 1'b0;
      ovf0 <= 1'b0;
      ovf1 <= 1'b0;
    end else begin
      if (setup) prdata <= rd_mux;
      if (idata_acc) instr_write_pointer <= instr_write_pointer + 6'h01;
      else if (wr_acc && hit_iptr) instr_write_pointer <= apb.pwdata[IDX_W-1:0];
      if (wr_acc && hit_bound) instr_start_boundary <= apb.pwdata[IDX_W-1:0];
      if (wr_acc && hit_xstart) xram_start <= apb.pwdata[15:0];
      if (wr_acc && hit_rlimit) repeat_limit <= apb.pwdata[15:0];
      if (ctrl_wr) begin
        engine_mode_select <= apb.pwdata[CTL_MODE];
        offchip_halt <= apb.pwdata[CTL_HALT];
      end
      ovf0 <= lost0 | (ovf0 & ~(ctrl_wr & apb.pwdata[CTL_OVF0]));
      ovf1 <= lost1 | (ovf1 & ~(ctrl_wr & apb.pwdata[CTL_OVF1]));
    end
  end

  // Result holding buffers; a result arriving on a full buffer is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf0_valid <= 1'b0;
      buf1_valid <= 1'b0;
      buf0 <= RST_16;
      buf1 <= RST_16;
    end else begin
      buf0_valid <= active & ((buf0_valid & ~consume0) | (first_conv_done & cap_ok0 & ~lost0));
      buf1_valid <= active & ((buf1_valid & ~consume1) | (second_conv_done & cap_ok1 & ~lost1));
      if (first_conv_done && cap_ok0 && !lost0) buf0 <= first_conv_result;
      if (second_conv_done && cap_ok1 && !lost1) buf1 <= second_conv_result;
    end
  end

  // Sequencer; mode 1 is not implemented and runs as mode 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      current_instr_index <= RST_IDX;
      xram_ptr <= RST_16;
      repeat_count <= RST_16;
      cur_ins <= 8'h00;
      wr_shift <= 32'h0000_0000;
      wr_addr <= RST_16;
      wr_left <= 3'h0;
      wr_total <= 3'h0;
    end else if (stop_req) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_req) begin
            xram_ptr <= xram_start;
            repeat_count <= repeat_limit;
            current_instr_index <= instr_start_boundary;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          cur_ins <= ibuf[current_instr_index];
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (fetched_eop) begin
            current_instr_index <= instr_start_boundary;
            if (!cur_ins[INS_CONTINUOUS_CONVERSION_FLAG]) repeat_count <= count_dec;
            state <= run_out ? S_IDLE : S_FETCH;
          end else if (data_ready) begin
            // Second word follows the first; high byte goes to the lower address
            wr_shift <= want0 ? {buf0, buf1} : {buf1, RST_16};
            wr_addr <= xram_ptr;
            wr_left <= ins_bytes(cur_ins);
            wr_total <= ins_bytes(cur_ins);
            state <= S_WRITE;
          end
        end
        S_WRITE: begin
          // Off-chip bytes wait here while halt is set
          if (grant) begin
            wr_shift <= {wr_shift[23:0], 8'h00};
            wr_addr <= wr_addr + 16'h0001;
            wr_left <= wr_left - 3'h1;
          end
          if (last_byte) begin
            xram_ptr <= xram_ptr + {13'h0000, wr_total};
            current_instr_index <= current_instr_index + 6'h01;
            state <= S_FETCH;
          end
        end
      endcase
    end
  end

  default clocking dflt @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IPTR_STEP: assert property (idata_acc |=> instr_write_pointer == $past(instr_write_pointer) + 6'h01)
    else $error("write pointer did not advance after data port access");
  AST_ONCHIP_FREE: assert property (onchip_we |-> !core_onchip_busy)
    else $error("on-chip write while core uses XRAM");
  AST_HALT_OWNER: assert property (offchip_halt |-> !eng_off_we)
    else $error("engine wrote off-chip while halted");
  AST_CORE_MUTE: assert property (!offchip_halt |-> core_offchip_rdata == 8'h00 && !ext_xram.re)
    else $error("core reached off-chip memory without ownership");
  AST_HOLD_PENDING: assert property ((state == S_WRITE && to_offchip && offchip_halt && !stop_req)
    |=> state == S_WRITE && wr_left == $past(wr_left))
    else $error("pending off-chip write moved while halted");
  AST_OVF_SET: assert property (lost0 |=> ovf0)
    else $error("overflow not flagged for dropped result");
  AST_START_LOAD: assert property (start_req |=> xram_ptr == $past(xram_start) && repeat_count == $past(repeat_limit)
    && current_instr_index == $past(instr_start_boundary))
    else $error("start did not load pointer, counter and index");
  AST_PTR_GROW: assert property (last_byte && !stop_req |=> xram_ptr == $past(xram_ptr) + {13'h0000, $past(wr_total)})
    else $error("XRAM pointer did not grow by bytes written");
  AST_EOP_WRAP: assert property (state == S_WAIT && fetched_eop && !stop_req
    |=> current_instr_index == instr_start_boundary)
    else $error("index not reset at end of operation");
  AST_RUN_OUT: assert property (state == S_WAIT && fetched_eop && run_out && !stop_req |=> state == S_IDLE)
    else $error("engine kept running after repeat counter expired");
  AST_BUSY_FLAG: assert property (eng_off_we |-> offchip_busy)
    else $error("busy flag low during off-chip write");
endmodule : conv_xram_dma

/* conv_partner.sv */
// Far-side model: two converters, core on-chip activity and XRAM storage.
// Assumes the bench pulses fire0/fire1 on pclk and reads mem hierarchically.
`timescale 1ns/1ps
module conv_partner (
  input wire logic pclk,
  input wire logic fire0,
  input wire logic fire1,
  input wire logic [15:0] val0,
  input wire logic [15:0] val1,
  input wire logic stall,
  output logic first_conv_done,
  output logic [15:0] first_conv_result,
  output logic second_conv_done,
  output logic [15:0] second_conv_result,
  output logic core_onchip_busy,
  input wire logic onchip_we,
  input wire logic [15:0] xram_addr,
  input wire logic [7:0] xram_wdata,
  input wire dma_pkg::xram_acc_t ext_xram,
  output logic [7:0] ext_rdata
);
  import dma_pkg::*;
  logic [7:0] mem [0:65535];
  initial first_conv_done = 1'b0;
  initial second_conv_done = 1'b0;
  initial core_onchip_busy = 1'b0;
  // Results are inverted off the done cycle so a late sample shows up
  assign first_conv_result = first_conv_done ? val0 : ~val0;
  assign second_conv_result = second_conv_done ? val1 : ~val1;
  assign ext_rdata = mem[ext_xram.addr];
  // Converters run on their own; busy toggles so the engine must find gaps
  always @(posedge pclk) begin
    first_conv_done <= fire0;
    second_conv_done <= fire1;
    core_onchip_busy <= stall & ~core_onchip_busy;
    if (onchip_we) mem[xram_addr] <= xram_wdata;
    if (ext_xram.we) mem[ext_xram.addr] <= ext_xram.data;
  end
endmodule : conv_partner

/* tb_top.sv */
// Self-checking bench for the converter-to-XRAM engine.
// Assumes the design answers APB with no wait states but waits on pready anyway.
`timescale 1ns/1ps
module tb_top;
  import dma_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t apb = '0;
  xram_acc_t core_offchip = '0;
  xram_acc_t ext_xram;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, slv, fire0 = 0, fire1 = 0, stall = 0;
  logic [15:0] val0 = '0, val1 = '0, xram_addr, r0, r1;
  logic d0, d1, cbusy, onchip_we;
  logic [7:0] xram_wdata, core_offchip_rdata, ext_rdata, crd;
  int fail_count = 0;
  int total_checks = 0;

  always #12.5 pclk = ~pclk;

  conv_xram_dma i_conv_xram_dma (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_conv_done(d0), .first_conv_result(r0),
    .second_conv_done(d1), .second_conv_result(r1), .core_onchip_busy(cbusy),
    .onchip_we(onchip_we), .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .core_offchip(core_offchip), .core_offchip_rdata(core_offchip_rdata),
    .ext_xram(ext_xram), .ext_rdata(ext_rdata));
  conv_partner i_conv_partner (.pclk(pclk), .fire0(fire0), .fire1(fire1), .val0(val0),
    .val1(val1), .stall(stall), .first_conv_done(d0), .first_conv_result(r0),
    .second_conv_done(d1), .second_conv_result(r1), .core_onchip_busy(cbusy),
    .onchip_we(onchip_we), .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .ext_xram(ext_xram), .ext_rdata(ext_rdata));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    slv = pslverr;
    apb <= '0;
  endtask : xfer

  // Bounded poll; the engine's pace depends on stalls, so no fixed wait
  task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] e);
    for (int i = 0; i < 300; i++) begin
      xfer(1'b0, a, 32'h0);
      if (rdv === e) break;
    end
    chk(nm, e, rdv);
  endtask : poll

  // Four cycles let the engine pass fetch and reach its wait state
  task automatic fire(input logic f0, input logic f1, input logic [15:0] v0, input logic [15:0] v1);
    repeat (4) @(posedge pclk);
    fire0 <= f0;
    fire1 <= f1;
    val0 <= v0;
    val1 <= v1;
    @(posedge pclk);
    fire0 <= 1'b0;
    fire1 <= 1'b0;
  endtask : fire

  task automatic core(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    core_offchip <= '{we: w, re: !w, addr: a, data: d};
    @(posedge pclk);
    crd = core_offchip_rdata;
    core_offchip <= '0;
  endtask : core

  task automatic t_ibuf();
    xfer(1'b1, OFS_IPTR, 32'h3E);
    xfer(1'b1, OFS_IDATA, 32'h10);
    xfer(1'b1, OFS_IDATA, 32'h30);
    xfer(1'b0, OFS_IPTR, 32'h0);
    chk("iptr wrap", 32'h0, rdv);
    xfer(1'b1, OFS_IPTR, 32'h3F);
    xfer(1'b0, OFS_IDATA, 32'h0);
    chk("idata read", 32'h30, rdv);
    xfer(1'b0, OFS_IPTR, 32'h0);
    chk("iptr after read", 32'h0, rdv);
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped slverr", 32'h1, {31'h0, slv});
    // Mode bit alone; enable stays low so nothing starts
    xfer(1'b1, OFS_CTRL, 32'h2);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk("mode select", 32'h2, rdv);
  endtask : t_ibuf

  task automatic t_mode0();
    logic [7:0] ins [5] = '{8'h90, 8'h30, 8'h40, 8'h60, 8'h00};
    logic [15:0] a, b, p;
    logic [7:0] q [$];
    xfer(1'b1, OFS_IPTR, 32'h2);
    foreach (ins[i]) xfer(1'b1, OFS_IDATA, {24'h0, ins[i]});
    xfer(1'b1, OFS_BOUND, 32'h2);
    xfer(1'b1, OFS_XSTART, 32'h0100);
    xfer(1'b1, OFS_RLIMIT, 32'h2);
    stall <= 1'b1;
    xfer(1'b1, OFS_CTRL, 32'h1);
    xfer(1'b0, OFS_XPTR, 32'h0);
    chk("ptr start", 32'h0100, rdv);
    xfer(1'b0, OFS_CIDX, 32'h0);
    chk("index start", 32'h2, rdv);
    p = 16'h0100;
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 4; j++) begin
        a = 16'hA000 + 16'(k * 16 + j);
        b = 16'hB000 + 16'(k * 16 + j);
        fire(1'b1, ins[j][INS_SEC], a, b);
        q.push_back(a[15:8]);
        q.push_back(a[7:0]);
        if (ins[j][INS_SEC]) begin
          q.push_back(b[15:8]);
          q.push_back(b[7:0]);
        end
        p = p + (ins[j][INS_SEC] ? 16'h4 : 16'h2);
        poll("xram ptr", OFS_XPTR, {16'h0, p});
      end
    end
    poll("engine idle", OFS_CTRL, 32'h0);
    xfer(1'b0, OFS_CIDX, 32'h0);
    chk("index at boundary", 32'h2, rdv);
    xfer(1'b0, OFS_RCOUNT, 32'h0);
    chk("count expired", 32'h0, rdv);
    foreach (q[i]) chk("xram byte", {24'h0, q[i]}, {24'h0, i_conv_partner.mem[16'h0100 + i]});
    stall <= 1'b0;
  endtask : t_mode0

  task automatic t_offchip();
    xfer(1'b1, OFS_IPTR, 32'h0);
    xfer(1'b1, OFS_IDATA, 32'h20);
    xfer(1'b1, OFS_IDATA, 32'h80);
    xfer(1'b1, OFS_BOUND, 32'h0);
    xfer(1'b1, OFS_XSTART, 32'h2000);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk("busy before halt", 32'h0, {31'h0, rdv[CTL_BUSY]});
    xfer(1'b1, OFS_CTRL, 32'h5);
    core(1'b1, 16'h3000, 8'h77);
    core(1'b0, 16'h3000, 8'h00);
    chk("core read halted", 32'h77, {24'h0, crd});
    fire(1'b0, 1'b1, 16'h0, 16'hC5D6);
    // Long enough for an unheld write to have landed
    repeat (12) @(posedge pclk);
    xfer(1'b0, OFS_XPTR, 32'h0);
    chk("ptr held", 32'h2000, rdv);
    // A second result on the still-full buffer is lost and flagged
    fire(1'b0, 1'b1, 16'h0, 16'h1234);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk("overflow flags", 32'h2, {30'h0, rdv[CTL_OVF1], rdv[CTL_OVF0]});
    // The write releasing halt also sets the OVF1 bit, which clears the sticky flag, so later reads see zero
    xfer(1'b1, OFS_CTRL, 32'h21);
    poll("offchip ptr", OFS_XPTR, 32'h2002);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl running", 32'h1, rdv);
    chk("offchip hi", 32'hC5, {24'h0, i_conv_partner.mem[16'h2000]});
    chk("offchip lo", 32'hD6, {24'h0, i_conv_partner.mem[16'h2001]});
    fire(1'b0, 1'b1, 16'h0, 16'hE7F8);
    poll("continuous ptr", OFS_XPTR, 32'h2004);
    xfer(1'b0, OFS_RCOUNT, 32'h0);
    chk("count ignored", 32'h2, rdv);
    core(1'b1, 16'h3000, 8'h11);
    core(1'b0, 16'h3000, 8'h00);
    chk("core read dropped", 32'h0, {24'h0, crd});
    chk("core write dropped", 32'h77, {24'h0, i_conv_partner.mem[16'h3000]});
    xfer(1'b1, OFS_CTRL, 32'h0);
    poll("stopped", OFS_CTRL, 32'h0);
  endtask : t_offchip

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_ibuf();
    t_mode0();
    t_offchip();
    complete_run();
  end
endmodule : tb_top
